// ==== controller_system_status_bits_tb.sv ====
// Purpose: self-checking bench for the system bit bank
// Assumes: two-cycle apb transfers
// Notes: ctrl_m mirrors the ctrl register
`default_nettype none

module controller_system_status_bits_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, irq;
  logic [7:0] paddr, rfault, lamp, mod_err;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0] evp, cs_idx;
  logic ev_cfg, rtc_abs, rtc_inv, card_ok, ram_ok, slave;
  logic disp, health, cpu_lamp, cs_stb, adj_act, adj_stb, cnt_clr;
  logic [15:0] cs_dat, adj_word;
  logic [63:0] dtw;
  int fail_count, comparisons, cyc, set_cnt, adj_cnt, ctrl_m;
  int set_q[$], adj_q[$];
  logic [7:0] rprev;

  sysbits_bank u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .event_task_configured(ev_cfg),
    .event_stack_overflow(evp[0]), .event_dispatch_enable(disp),
    .rack_fault(rfault), .general_io_health(health),
    .rack_fault_lamp(lamp), .cpu_fault_lamp(cpu_lamp),
    .module_error_set(mod_err), .rtc_absent(rtc_abs),
    .rtc_words_invalid(rtc_inv), .date_time_words(dtw),
    .clock_set_strobe(cs_stb), .clock_set_index(cs_idx),
    .clock_set_data(cs_dat), .clock_adjust_active(adj_act),
    .clock_adjust_strobe(adj_stb), .clock_adjust_word(adj_word),
    .card_battery_ok(card_ok), .ram_battery_ok(ram_ok),
    .terminal_slave_mode(slave), .message_counters_clear(cnt_clr),
    .shared_words_arrived(evp[1]), .irq
  );

  // ------
  // tasks
  // ------
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // model: accepted date and adjust writes must strobe once
    if (w && a >= sysbits_pkg::OFF_DT0 && a <= sysbits_pkg::OFF_DT3
      && a[1:0] == 2'h0 && ctrl_m[sysbits_pkg::CTRL_CLK_WSEL])
      set_q.push_back(((a - sysbits_pkg::OFF_DT0) / 4 << 16) | d[15:0]);
    if (w && a == sysbits_pkg::OFF_ADJ && ctrl_m[sysbits_pkg::CTRL_ADJ_EN])
      adj_q.push_back(d[15:0]);
    if (w && a == sysbits_pkg::OFF_CTRL) ctrl_m = d[3:0];
  endtask

  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------
  // clock, strobe counters, timeout
  // ------
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cs_stb === 1'b1)
    begin
      set_cnt++;
      if (set_q.size() == 0)
        chk("clock set", 1, 0);
      else
        chk("clock set", {cs_idx, cs_dat}, set_q.pop_front());
    end
    if (adj_stb === 1'b1)
    begin
      adj_cnt++;
      if (adj_q.size() == 0)
        chk("adjust", 1, 0);
      else
        chk("adjust", adj_word, adj_q.pop_front());
    end
    if (cyc == 5000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ------
  // tests
  // ------
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {evp, ev_cfg, rtc_abs, rtc_inv, slave, rfault} = '0;
    {card_ok, ram_ok} = 2'b11;
    void'($urandom(32'h42e412cc));
    dtw = {$urandom, $urandom};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    ctrl_m = 1;
    apb(0, sysbits_pkg::OFF_CTRL, 0);
    chk("ctrl", rdata, ctrl_m);
    apb(0, sysbits_pkg::OFF_STATUS, 0);
    chk("status", rdata & ~32'h100, 32'h10ff);
    apb(0, sysbits_pkg::OFF_IRQ_MASK, 0);
    chk("mask", rdata, 0);
    chk("dispatch", disp, 1'b0);
    ev_cfg <= 1'b1;
    @(negedge pclk);
    chk("dispatch", disp, 1'b1);
    apb(1, sysbits_pkg::OFF_CTRL, 0);
    @(negedge pclk);
    chk("dispatch", disp, 1'b0);
    apb(1, sysbits_pkg::OFF_CTRL, 1);
    $display("reset and enable done");

    apb(1, sysbits_pkg::OFF_IRQ_MASK, 32'h1);
    apb(1, sysbits_pkg::OFF_IRQ_STAT, 32'h1f);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      evp[i] <= 1'b1;
      @(posedge pclk);
      evp[i] <= 1'b0;
      repeat (3) @(negedge pclk);
      chk("irq", irq, i == 0);
      apb(1, sysbits_pkg::OFF_FLAGS, 32'h3);
      apb(0, sysbits_pkg::OFF_FLAGS, 0);
      chk("flags", rdata, 32'h1 << i);
      apb(1, sysbits_pkg::OFF_FLAGS, 0);
      apb(0, sysbits_pkg::OFF_FLAGS, 0);
      chk("flags", rdata, 0);
      apb(1, sysbits_pkg::OFF_IRQ_STAT, 32'h3);
      repeat (2) @(negedge pclk);
      chk("irq", irq, 1'b0);
    end
    $display("flags done");

    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      rprev = rfault;
      rfault <= (i == 3) ? 8'h00 : 8'($urandom);
      {card_ok, ram_ok, slave} <= 3'($urandom);
      repeat (2) @(negedge pclk);
      chk("lamp", lamp, rfault);
      chk("cpu lamp", cpu_lamp, |rfault);
      chk("health", health, rfault == 0);
      chk("module error", mod_err, rfault & ~rprev);
      apb(0, sysbits_pkg::OFF_STATUS, 0);
      chk("status", rdata & ~32'h100, {rfault == 0, slave, ~ram_ok,
        ~card_ok, 1'b0, ~rfault});
    end
    $display("racks done");

    @(posedge pclk);
    rtc_inv <= 1'b1;
    @(posedge pclk);
    rtc_inv <= 1'b0;
    apb(0, sysbits_pkg::OFF_STATUS, 0);
    chk("clock invalid", rdata[8], 1'b1);
    set_cnt = 0;
    apb(1, sysbits_pkg::OFF_DT0 + 8'h08, 32'hbeef);
    apb(1, sysbits_pkg::OFF_CTRL, 32'h3);
    chk("set count", set_cnt, 0);
    apb(1, sysbits_pkg::OFF_DT0 + 8'h08, 32'ha5c3);
    repeat (2) @(negedge pclk);
    chk("set count", set_cnt, 1);
    chk("set index", cs_idx, 2'h2);
    chk("set data", cs_dat, 16'ha5c3);
    apb(0, sysbits_pkg::OFF_STATUS, 0);
    chk("clock invalid", rdata[8], 1'b0);
    apb(0, sysbits_pkg::OFF_DT0 + 8'h04, 0);
    chk("date", rdata, dtw[31:16]);
    rtc_abs <= 1'b1;
    apb(1, sysbits_pkg::OFF_DT0, 32'h0011);
    apb(0, sysbits_pkg::OFF_STATUS, 0);
    chk("clock invalid", rdata[8], 1'b1);
    rtc_abs <= 1'b0;
    $display("clock done");

    adj_cnt = 0;
    apb(1, sysbits_pkg::OFF_ADJ, 32'h1234);
    apb(1, sysbits_pkg::OFF_CTRL, 32'h5);
    chk("adjust count", adj_cnt, 0);
    apb(1, sysbits_pkg::OFF_ADJ, 32'h5678);
    repeat (2) @(negedge pclk);
    chk("adjust count", adj_cnt, 1);
    chk("adjust word", adj_word, 16'h5678);
    chk("adjust active", adj_act, 1'b1);
    apb(1, sysbits_pkg::OFF_CTRL, 32'h9);
    repeat (5) @(negedge pclk);
    chk("counter clear", cnt_clr, 1'b1);
    apb(1, sysbits_pkg::OFF_CTRL, 32'h1);
    apb(0, sysbits_pkg::OFF_CTRL, 0);
    chk("counter clear", cnt_clr, 1'b0);
    $display("adjust and counters done");

    apb(0, 8'h40, 0);
    chk("error", serr, 1'b1);
    chk("bad read", rdata, 0);
    apb(1, 8'h02, 32'hffffffff);
    chk("error", serr, 1'b1);
    apb(0, sysbits_pkg::OFF_CTRL, 0);
    chk("ctrl", rdata, ctrl_m);
    $display("unmapped done");

    apb(1, sysbits_pkg::OFF_CTRL, 32'hf);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ctrl_m = 1;
    apb(0, sysbits_pkg::OFF_CTRL, 0);
    chk("ctrl", rdata, ctrl_m);
    chk("counter clear", cnt_clr, 1'b0);
    chk("adjust active", adj_act, 1'b0);
    chk("set queue", set_q.size(), 0);
    chk("adjust queue", adj_q.size(), 0);
    $display("second reset done");
    summarize();
  end
endmodule // controller_system_status_bits_tb

`default_nettype wire

// ==== sticky_bits.sv ====
// Purpose: bank of sticky flags, set by hardware, cleared by software
// Assumes: set and clear are one-cycle requests per bit
// Notes: a set in the clearing cycle wins
`default_nettype none

module sticky_bits #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // per-bit requests
  input wire logic [W-1:0] set_bits,
  input wire logic [W-1:0] clear_bits,
  // current flags
  output logic [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } sticky_t;

  sticky_t s_q;
  sticky_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.flags = (s_q.flags & ~clear_bits) | set_bits;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign flags = s_q.flags;

endmodule // sticky_bits

`default_nettype wire

// ==== sysbits_bank.sv ====
// Purpose: system control and status bit bank behind an apb slave
// Assumes: all system-side inputs synchronous to pclk
// Notes: zero wait state bus, read data latched in setup phase
//
// The APB interface to the registers and the register offsets were decided locally.
`default_nettype none

module sysbits_bank (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sysbits_pkg::ADDR_W-1:0] paddr,
  input wire logic [sysbits_pkg::DATA_W-1:0] pwdata,
  output logic [sysbits_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // event processing
  input wire logic event_task_configured,
  input wire logic event_stack_overflow,
  output logic event_dispatch_enable,
  // rack faults
  input wire logic [sysbits_pkg::RACKS-1:0] rack_fault,
  output logic general_io_health,
  output logic [sysbits_pkg::RACKS-1:0] rack_fault_lamp,
  output logic cpu_fault_lamp,
  output logic [sysbits_pkg::RACKS-1:0] module_error_set,
  // real-time clock
  input wire logic rtc_absent,
  input wire logic rtc_words_invalid,
  input wire logic [sysbits_pkg::DT_WORDS*sysbits_pkg::DT_W-1:0]
    date_time_words,
  output logic clock_set_strobe,
  output logic [1:0] clock_set_index,
  output logic [sysbits_pkg::DT_W-1:0] clock_set_data,
  output logic clock_adjust_active,
  output logic clock_adjust_strobe,
  output logic [sysbits_pkg::ADJ_W-1:0] clock_adjust_word,
  // batteries and terminal port
  input wire logic card_battery_ok,
  input wire logic ram_battery_ok,
  input wire logic terminal_slave_mode,
  // message counters and shared words
  output logic message_counters_clear,
  input wire logic shared_words_arrived,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic ev_en;
    logic clk_wsel;
    logic adj_en;
    logic cnt_clr;
    logic [sysbits_pkg::RACKS-1:0] rack_ok;
    logic [sysbits_pkg::RACKS-1:0] rack_fall;
    logic clk_inv;
    logic card_bf;
    logic ram_bf;
    logic term_role;
    logic [sysbits_pkg::ADJ_W-1:0] adj_word;
    logic adj_stb;
    logic [sysbits_pkg::DT_W-1:0] set_data;
    logic [1:0] set_idx;
    logic set_stb;
    logic [sysbits_pkg::IRQ_W-1:0] irq_mask;
    logic [sysbits_pkg::DATA_W-1:0] prdata;
  } state_t;

  localparam state_t STATE_RST = '{
    ev_en: sysbits_pkg::EV_EN_RST,
    clk_wsel: sysbits_pkg::CLK_WSEL_RST,
    adj_en: sysbits_pkg::ADJ_EN_RST,
    cnt_clr: sysbits_pkg::CNT_CLR_RST,
    rack_ok: sysbits_pkg::RACK_OK_RST,
    irq_mask: sysbits_pkg::IRQ_MASK_RST,
    default: '0
  };

  state_t s_q;
  state_t s_d;

  logic setup_ph;
  logic wr_acc;
  logic mapped;
  logic is_dt;
  logic [1:0] dt_idx;
  logic [sysbits_pkg::ADDR_W-1:0] dt_off;
  logic [sysbits_pkg::DATA_W-1:0] rd_val;
  logic [sysbits_pkg::FLAG_W-1:0] flag_set;
  logic [sysbits_pkg::FLAG_W-1:0] flag_clr;
  logic [sysbits_pkg::FLAG_W-1:0] flags;
  logic [sysbits_pkg::IRQ_W-1:0] irq_set;
  logic [sysbits_pkg::IRQ_W-1:0] irq_clr;
  logic [sysbits_pkg::IRQ_W-1:0] irq_stat;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign dt_off = paddr - sysbits_pkg::OFF_DT0;
  assign is_dt = (paddr >= sysbits_pkg::OFF_DT0)
    && (paddr <= sysbits_pkg::OFF_DT3) && (paddr[1:0] == 2'h0);
  assign dt_idx = dt_off[3:2];

  always_comb
  begin
    mapped = 1'b1;
    case (paddr)
      sysbits_pkg::OFF_CTRL,
      sysbits_pkg::OFF_FLAGS,
      sysbits_pkg::OFF_STATUS,
      sysbits_pkg::OFF_IRQ_STAT,
      sysbits_pkg::OFF_IRQ_MASK,
      sysbits_pkg::OFF_ADJ: mapped = 1'b1;
      default: mapped = is_dt;
    endcase
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb
  begin
    rd_val = '0;
    case (paddr)
      sysbits_pkg::OFF_CTRL:
      begin
        rd_val[sysbits_pkg::CTRL_EV_EN] = s_q.ev_en;
        rd_val[sysbits_pkg::CTRL_CLK_WSEL] = s_q.clk_wsel;
        rd_val[sysbits_pkg::CTRL_ADJ_EN] = s_q.adj_en;
        rd_val[sysbits_pkg::CTRL_CNT_CLR] = s_q.cnt_clr;
      end
      sysbits_pkg::OFF_FLAGS:
        rd_val[sysbits_pkg::FLAG_W-1:0] = flags;
      sysbits_pkg::OFF_STATUS:
      begin
        rd_val[sysbits_pkg::ST_RACK_LSB +: sysbits_pkg::RACKS] =
          s_q.rack_ok;
        rd_val[sysbits_pkg::ST_CLK_INV] = s_q.clk_inv;
        rd_val[sysbits_pkg::ST_CARD_BATT] = s_q.card_bf;
        rd_val[sysbits_pkg::ST_RAM_BATT] = s_q.ram_bf;
        rd_val[sysbits_pkg::ST_TERM_ROLE] = s_q.term_role;
        rd_val[sysbits_pkg::ST_IO_HEALTH] = &s_q.rack_ok;
      end
      sysbits_pkg::OFF_IRQ_STAT:
        rd_val[sysbits_pkg::IRQ_W-1:0] = irq_stat;
      sysbits_pkg::OFF_IRQ_MASK:
        rd_val[sysbits_pkg::IRQ_W-1:0] = s_q.irq_mask;
      sysbits_pkg::OFF_ADJ:
        rd_val[sysbits_pkg::ADJ_W-1:0] = s_q.adj_word;
      default:
      begin
        if (is_dt)
        begin
          // date words always read the live clock
          rd_val[sysbits_pkg::DT_W-1:0] =
            date_time_words[dt_idx*sysbits_pkg::DT_W +: sysbits_pkg::DT_W];
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.set_stb = 1'b0;
    s_d.adj_stb = 1'b0;
    // rack ok bits follow the fault inputs
    s_d.rack_ok = ~rack_fault;
    s_d.rack_fall = s_q.rack_ok & rack_fault;
    s_d.card_bf = ~card_battery_ok;
    s_d.ram_bf = ~ram_battery_ok;
    s_d.term_role = terminal_slave_mode;
    if (setup_ph && !pwrite)
    begin
      s_d.prdata = rd_val;
    end
    if (wr_acc)
    begin
      case (paddr)
        sysbits_pkg::OFF_CTRL:
        begin
          s_d.ev_en = pwdata[sysbits_pkg::CTRL_EV_EN];
          s_d.clk_wsel = pwdata[sysbits_pkg::CTRL_CLK_WSEL];
          s_d.adj_en = pwdata[sysbits_pkg::CTRL_ADJ_EN];
          s_d.cnt_clr = pwdata[sysbits_pkg::CTRL_CNT_CLR];
        end
        sysbits_pkg::OFF_IRQ_MASK:
          s_d.irq_mask = pwdata[sysbits_pkg::IRQ_W-1:0];
        sysbits_pkg::OFF_ADJ:
        begin
          s_d.adj_word = pwdata[sysbits_pkg::ADJ_W-1:0];
          s_d.adj_stb = s_q.adj_en;
        end
        default:
        begin
          // date writes reach the clock only when selected
          if (is_dt && s_q.clk_wsel)
          begin
            s_d.set_stb = 1'b1;
            s_d.set_idx = dt_idx;
            s_d.set_data = pwdata[sysbits_pkg::DT_W-1:0];
          end
        end
      endcase
    end
    // a clock set clears the flag, a loss in the same cycle wins
    s_d.clk_inv = (s_q.clk_inv & ~s_d.set_stb)
      | rtc_absent | rtc_words_invalid;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // software flags: event loss and shared words
  // ------------------------------------------------------------
  always_comb
  begin
    flag_set = '0;
    flag_set[sysbits_pkg::FLAG_EV_LOSS] = event_stack_overflow;
    flag_set[sysbits_pkg::FLAG_SHARED] = shared_words_arrived;
    flag_clr = '0;
    if (wr_acc && (paddr == sysbits_pkg::OFF_FLAGS))
    begin
      // writing 0 to a bit clears it
      flag_clr = ~pwdata[sysbits_pkg::FLAG_W-1:0];
    end
  end

  sticky_bits #(
    .W(sysbits_pkg::FLAG_W)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_bits(flag_set),
    .clear_bits(flag_clr),
    .flags(flags)
  );

  // ------------------------------------------------------------
  // interrupt status, write 1 clears
  // ------------------------------------------------------------
  always_comb
  begin
    irq_set = '0;
    irq_set[sysbits_pkg::IRQ_EV_LOSS] = event_stack_overflow;
    irq_set[sysbits_pkg::IRQ_SHARED] = shared_words_arrived;
    irq_set[sysbits_pkg::IRQ_RACK] = |s_q.rack_fall;
    irq_set[sysbits_pkg::IRQ_CLK_INV] = s_d.clk_inv & ~s_q.clk_inv;
    irq_set[sysbits_pkg::IRQ_BATT] = (s_d.card_bf & ~s_q.card_bf)
      | (s_d.ram_bf & ~s_q.ram_bf);
    irq_clr = '0;
    if (wr_acc && (paddr == sysbits_pkg::OFF_IRQ_STAT))
    begin
      irq_clr = pwdata[sysbits_pkg::IRQ_W-1:0];
    end
  end

  sticky_bits #(
    .W(sysbits_pkg::IRQ_W)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .set_bits(irq_set),
    .clear_bits(irq_clr),
    .flags(irq_stat)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ------------------------------------------------------------
  // system-side outputs
  // ------------------------------------------------------------

  // events run only with an event task and the enable set
  assign event_dispatch_enable =
    event_task_configured && s_q.ev_en;

  assign general_io_health = &s_q.rack_ok;
  assign rack_fault_lamp = ~s_q.rack_ok;
  assign cpu_fault_lamp = ~(&s_q.rack_ok);
  assign module_error_set = s_q.rack_fall;

  assign clock_set_strobe = s_q.set_stb;
  assign clock_set_index = s_q.set_idx;
  assign clock_set_data = s_q.set_data;
  assign clock_adjust_active = s_q.adj_en;
  assign clock_adjust_strobe = s_q.adj_stb;
  assign clock_adjust_word = s_q.adj_word;

  // held until software writes the bit back to 0
  assign message_counters_clear = s_q.cnt_clr;

  // ------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------
  // level, high while any unmasked status bit is set
  assign irq = |(irq_stat & s_q.irq_mask);

endmodule // sysbits_bank

`default_nettype wire

// ==== sysbits_bank_monitor.sv ====
// Purpose: port checks on the system bit bank
// Assumes: one pclk domain
// Notes: bound to every bank
`default_nettype none

module sysbits_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sysbits_pkg::ADDR_W-1:0] paddr,
  input wire logic [sysbits_pkg::DATA_W-1:0] pwdata,
  // system side
  input wire logic event_task_configured,
  input wire logic event_dispatch_enable,
  input wire logic [sysbits_pkg::RACKS-1:0] rack_fault,
  input wire logic general_io_health,
  input wire logic [sysbits_pkg::RACKS-1:0] rack_fault_lamp,
  input wire logic cpu_fault_lamp,
  input wire logic [sysbits_pkg::RACKS-1:0] module_error_set,
  input wire logic clock_set_strobe,
  input wire logic clock_adjust_active,
  input wire logic clock_adjust_strobe,
  input wire logic message_counters_clear
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic date_wr;
  assign date_wr = psel && penable && pwrite
    && paddr >= sysbits_pkg::OFF_DT0 && paddr <= sysbits_pkg::OFF_DT3;

  sequence s_ctrl_wr;
    psel && penable && pwrite && paddr == sysbits_pkg::OFF_CTRL;
  endsequence

  a_dispatch_task: assert property (
    event_dispatch_enable |-> event_task_configured)
    else $error("dispatch without event task");
  a_lamp_follow: assert property (
    1 |=> rack_fault_lamp == $past(rack_fault))
    else $error("rack lamp not following fault");
  a_health_lamp: assert property (
    general_io_health == (rack_fault_lamp == '0)
    && cpu_fault_lamp == |rack_fault_lamp)
    else $error("health or cpu lamp wrong");
  a_module_err: assert property (
    module_error_set == (rack_fault_lamp & ~$past(rack_fault_lamp)))
    else $error("module error pulse wrong");
  a_counter_clear: assert property (
    s_ctrl_wr |=> message_counters_clear
      == $past(pwdata[sysbits_pkg::CTRL_CNT_CLR]))
    else $error("counter clear not written");
  a_adjust_active: assert property (
    s_ctrl_wr |=> clock_adjust_active
      == $past(pwdata[sysbits_pkg::CTRL_ADJ_EN]))
    else $error("adjust enable not written");
  a_adjust_gate: assert property (
    clock_adjust_strobe |-> clock_adjust_active)
    else $error("adjust strobe while disabled");
  a_set_cause: assert property (
    clock_set_strobe |-> $past(date_wr))
    else $error("clock set without date write");
endmodule // sysbits_monitor

bind sysbits_bank sysbits_monitor u_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .event_task_configured, .event_dispatch_enable, .rack_fault,
  .general_io_health, .rack_fault_lamp, .cpu_fault_lamp,
  .module_error_set, .clock_set_strobe, .clock_adjust_active,
  .clock_adjust_strobe, .message_counters_clear
);

`default_nettype wire

// ==== sysbits_pkg.sv ====
// Purpose: shared constants for the system status bit bank
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: offsets are byte addresses
`default_nettype none

package sysbits_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RACKS = 8;
  localparam int DT_WORDS = 4;
  localparam int DT_W = 16;
  localparam int ADJ_W = 16;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ADJ = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DT0 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_DT3 = 8'h24;

  // ------------------------------------------------------------
  // ctrl fields
  // ------------------------------------------------------------
  localparam int CTRL_EV_EN = 0;
  localparam int CTRL_CLK_WSEL = 1;
  localparam int CTRL_ADJ_EN = 2;
  localparam int CTRL_CNT_CLR = 3;
  localparam logic EV_EN_RST = 1'b1;
  localparam logic CLK_WSEL_RST = 1'b0;
  localparam logic ADJ_EN_RST = 1'b0;
  localparam logic CNT_CLR_RST = 1'b0;

  // ------------------------------------------------------------
  // flags fields (write 0 clears)
  // ------------------------------------------------------------
  localparam int FLAG_W = 2;
  localparam int FLAG_EV_LOSS = 0;
  localparam int FLAG_SHARED = 1;

  // ------------------------------------------------------------
  // status fields (read only)
  // ------------------------------------------------------------
  localparam int ST_RACK_LSB = 0;
  localparam int ST_CLK_INV = 8;
  localparam int ST_CARD_BATT = 9;
  localparam int ST_RAM_BATT = 10;
  localparam int ST_TERM_ROLE = 11;
  localparam int ST_IO_HEALTH = 12;
  localparam logic [RACKS-1:0] RACK_OK_RST = 8'hff;

  // ------------------------------------------------------------
  // interrupt sources (write 1 clears)
  // ------------------------------------------------------------
  localparam int IRQ_W = 5;
  localparam int IRQ_EV_LOSS = 0;
  localparam int IRQ_SHARED = 1;
  localparam int IRQ_RACK = 2;
  localparam int IRQ_CLK_INV = 3;
  localparam int IRQ_BATT = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

endpackage

`default_nettype wire
